// File: design/adc_pkg.sv
package adc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_REF_PORT_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_TIMING_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RUN_ON_BIT = 0;
  localparam int RUN_GO_BIT = 1;
  localparam int RUN_CHAN_LSB = 2;
  localparam int NEG_REF_BIT = 5;
  localparam int POS_REF_BIT = 4;
  localparam int TIMING_ACQ_LSB = 3;
  localparam int IRQ_DONE_BIT = 0;

  // ------------------------------------------------------------
  // Reset values and sizes
  // ------------------------------------------------------------
  localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
  localparam logic [3:0] PCFG_UPPER_DIGITAL = 4'h7;
  localparam logic [3:0] PCFG_LAST_ALL_ANALOG = 4'h2;
  localparam logic [12:0] ALL_PINS_ANALOG = 13'h1fff;
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [3:0] CONV_TADS = 4'hd;
  localparam logic [3:0] HOLDOFF_TADS = 4'h2;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

  typedef enum logic [1:0] {ST_SAMPLE, ST_ACQUIRE, ST_CONVERT, ST_HOLDOFF} conv_state_type;

endpackage : adc_pkg

// File: design/adc_sequencing_control.sv
`timescale 1ns/1ps

// What this block does
// - Negative reference bit 5: 1 selects pin AN2, 0 selects ground.
// - Positive reference bit 4: 1 selects pin AN3, 0 selects supply.
// - Codes 0-2 all analog; each higher code turns one more pin digital from AN12.
// - Bits 7:6 read zero; reference bits reset to zero.
// - At power-up pin config loads 0000 or 0111 from the reset option.
// - Conversion in sleep only runs on the internal RC conversion clock.
// - Result built by successive approximation on the held sample.
// - Reset turns converter off and aborts any running conversion.
// - On completion load result, clear start bit, set done flag.
// - Result registers unknown after power-up, kept across other resets.
// - Programmable acquisition time between start bit and conversion.
// - Next acquisition waits at least two conversion-clock periods after completion.
// - Each 12-bit conversion lasts thirteen conversion-clock periods.
// - Acquisition code 000 starts conversion at once when start is set.
// - After the holdoff sampling resumes, with no acquisition/convert indication.

module adc_sequencing_control
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state and options
  input wire logic analog_port_at_reset_option,
  input wire logic cpu_sleep,
  input wire logic rc_osc_tick,
  // Analog front end
  input wire logic comp_above,
  output logic [3:0] channel_sel,
  output logic sample_enable,
  output logic [11:0] dac_code,
  output logic neg_ref_select,
  output logic pos_ref_select,
  output logic [12:0] pin_analog_mask,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [12:0] analog_mask(input logic [3:0] code);
    if (code <= PCFG_LAST_ALL_ANALOG) begin
      analog_mask = ALL_PINS_ANALOG;
    end else begin
      analog_mask = ALL_PINS_ANALOG >> (code - PCFG_LAST_ALL_ANALOG);
    end
  endfunction : analog_mask

  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0c;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic on_q, on_d, go_q, go_d;
  logic [3:0] chan_q, chan_d;
  logic [5:0] refcfg_q, refcfg_d;
  logic [5:0] timing_q, timing_d;
  logic done_flag_q, done_flag_d, mask_q, mask_d, irq_q, irq_d;
  logic strap_taken_q, strap_taken_d;
  logic [12:0] pin_mask_q, pin_mask_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  conv_state_type state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [11:0] sar_q, sar_d, trial_q, trial_d;
  logic [11:0] result_q, result_d;
  logic sample_q, sample_d;
  logic tad_tick;
  logic access, wr, rd, mapped, finish;

  adc_tad_gen u_tad (
    .pclk(pclk),
    .presetn(presetn),
    .run(on_q),
    .cpu_sleep(cpu_sleep),
    .clk_select(timing_q[2:0]),
    .rc_osc_tick(rc_osc_tick),
    .tad_tick(tad_tick)
  );

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  always_comb begin
    access = psel && penable && pready_q;
    wr = access && pwrite;
    rd = access && !pwrite;
    mapped = (paddr <= ADDR_IRQ_MASK) && (paddr[1:0] == 2'h0);
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = prdata_q;
    if (pready_d) begin
      case (paddr)
        ADDR_RUN_CONTROL: prdata_d = {26'h0, chan_q, go_q, on_q};
        ADDR_REF_PORT_CONFIG: prdata_d = {26'h0, refcfg_q};
        ADDR_TIMING_CONFIG: prdata_d = {26'h0, timing_q};
        ADDR_RESULT_HIGH: prdata_d = {28'h0, result_q[11:8]};
        ADDR_RESULT_LOW: prdata_d = {24'h0, result_q[7:0]};
        ADDR_IRQ_STATUS: prdata_d = {31'h0, done_flag_q};
        ADDR_IRQ_MASK: prdata_d = {31'h0, mask_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration, start bit and interrupt
  // ------------------------------------------------------------
  always_comb begin
    on_d = on_q;
    chan_d = chan_q;
    refcfg_d = refcfg_q;
    timing_d = timing_q;
    mask_d = mask_q;
    go_d = go_q;
    strap_taken_d = 1'b1;
    done_flag_d = done_flag_q;
    if (!strap_taken_q) begin
      // Strap is caught after reset release, never under the async reset
      refcfg_d[3:0] = analog_port_at_reset_option ? PCFG_ALL_ANALOG : PCFG_UPPER_DIGITAL;
    end
    if (wr) begin
      case (paddr)
        ADDR_RUN_CONTROL: begin
          on_d = pwdata[RUN_ON_BIT];
          chan_d = pwdata[RUN_CHAN_LSB +: 4];
          go_d = go_q | (pwdata[RUN_GO_BIT] & pwdata[RUN_ON_BIT]);
        end
        ADDR_REF_PORT_CONFIG: refcfg_d = pwdata[5:0];
        ADDR_TIMING_CONFIG: timing_d = pwdata[5:0];
        ADDR_IRQ_MASK: mask_d = pwdata[IRQ_DONE_BIT];
        default: ;
      endcase
    end
    if (rd && paddr == ADDR_IRQ_STATUS) begin
      done_flag_d = 1'b0;
    end
    if (finish) begin
      go_d = 1'b0;
      done_flag_d = 1'b1;
    end
    if (!on_d) begin
      go_d = 1'b0;
    end
    irq_d = done_flag_d && mask_d;
    pin_mask_d = analog_mask(refcfg_d[3:0]);
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sar_d = sar_q;
    trial_d = trial_q;
    finish = 1'b0;
    result_d = result_q;
    case (state_q)
      ST_SAMPLE: begin
        if (go_q) begin
          cnt_d = 5'h00;
          sar_d = SAR_FIRST_TRIAL;
          trial_d = SAR_FIRST_TRIAL;
          if (timing_q[TIMING_ACQ_LSB +: 3] == ACQ_MANUAL) begin
            state_d = ST_CONVERT;
          end else begin
            state_d = ST_ACQUIRE;
          end
        end
      end
      ST_ACQUIRE: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q + 5'h01 >= acq_tads(timing_q[TIMING_ACQ_LSB +: 3])) begin
            cnt_d = 5'h00;
            state_d = ST_CONVERT;
          end
        end
      end
      ST_CONVERT: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q < 5'(CONV_TADS - 4'h1)) begin
            // Keep the trial bit only while the held sample sits at or above it
            sar_d = (comp_above ? sar_q : (sar_q & ~trial_q)) | (trial_q >> 1);
            trial_d = trial_q >> 1;
          end else begin
            finish = 1'b1;
            result_d = sar_q;
            cnt_d = 5'h00;
            state_d = ST_HOLDOFF;
          end
        end
      end
      ST_HOLDOFF: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q + 5'h01 >= 5'(HOLDOFF_TADS)) begin
            cnt_d = 5'h00;
            state_d = ST_SAMPLE;
          end
        end
      end
      default: state_d = ST_SAMPLE;
    endcase
    if (!on_q) begin
      state_d = ST_SAMPLE;
      cnt_d = 5'h00;
    end
    // Sampling shows no difference between acquiring and idle
    sample_d = on_d && (state_d == ST_SAMPLE || state_d == ST_ACQUIRE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      go_q <= 1'b0;
      chan_q <= 4'h0;
      refcfg_q <= 6'h00;
      timing_q <= 6'h00;
      mask_q <= 1'b0;
      done_flag_q <= 1'b0;
      irq_q <= 1'b0;
      strap_taken_q <= 1'b0;
      pin_mask_q <= ALL_PINS_ANALOG;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      state_q <= ST_SAMPLE;
      cnt_q <= 5'h00;
      sar_q <= 12'h000;
      trial_q <= 12'h000;
      sample_q <= 1'b0;
    end else begin
      on_q <= on_d;
      go_q <= go_d;
      chan_q <= chan_d;
      refcfg_q <= refcfg_d;
      timing_q <= timing_d;
      mask_q <= mask_d;
      done_flag_q <= done_flag_d;
      irq_q <= irq_d;
      strap_taken_q <= strap_taken_d;
      pin_mask_q <= pin_mask_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      sar_q <= sar_d;
      trial_q <= trial_d;
      sample_q <= sample_d;
    end
  end

  // Result has no reset so that it survives every reset
  always_ff @(posedge pclk) begin
    result_q <= result_d;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign channel_sel = chan_q;
  assign sample_enable = sample_q;
  assign dac_code = sar_q;
  assign neg_ref_select = refcfg_q[NEG_REF_BIT];
  assign pos_ref_select = refcfg_q[POS_REF_BIT];
  assign pin_analog_mask = pin_mask_q;
  assign irq = irq_q;

endmodule : adc_sequencing_control

// File: design/adc_tad_gen.sv
`timescale 1ns/1ps

module adc_tad_gen
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic cpu_sleep,
  input wire logic [2:0] clk_select,
  input wire logic rc_osc_tick,
  // Conversion clock period strobe
  output logic tad_tick
);

  // ------------------------------------------------------------
  // Divider for the system-clock based periods
  // ------------------------------------------------------------
  function automatic logic [5:0] tad_div_last(input logic [2:0] sel);
    case (sel)
      3'h0: tad_div_last = 6'h01;
      3'h4: tad_div_last = 6'h03;
      3'h1: tad_div_last = 6'h07;
      3'h5: tad_div_last = 6'h0f;
      3'h2: tad_div_last = 6'h1f;
      3'h6: tad_div_last = 6'h3f;
      default: tad_div_last = 6'h00;
    endcase
  endfunction : tad_div_last

  logic [5:0] div_q;
  logic [5:0] div_d;
  logic tick_q;
  logic tick_d;
  logic use_rc;

  always_comb begin
    use_rc = (clk_select[1:0] == CLK_SEL_RC);
    div_d = div_q;
    tick_d = 1'b0;
    if (!run) begin
      div_d = 6'h00;
    end else if (use_rc) begin
      div_d = 6'h00;
      tick_d = rc_osc_tick;
    end else if (!cpu_sleep) begin
      // System clock stops in sleep, so only the RC source keeps converting
      if (div_q >= tad_div_last(clk_select)) begin
        div_d = 6'h00;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tad_tick = tick_q;

endmodule : adc_tad_gen

// File: tb/adc_analog_model.sv
`timescale 1ns/1ps

module adc_analog_model (
  // Clock
  input wire logic pclk,
  // Front end
  input wire logic sample_enable,
  input wire logic [11:0] level,
  input wire logic [11:0] dac_code,
  output logic comp_above
);
  logic [11:0] held_q;

  // Hold capacitor follows the input only while sampling
  always_ff @(posedge pclk) begin
    if (sample_enable) held_q <= level;
  end
  assign comp_above = (held_q >= dac_code);
endmodule : adc_analog_model

// File: tb/adc_sequencing_control_props.sv
`timescale 1ns/1ps

module adc_sequencing_control_props
  import adc_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter side
  input wire logic cpu_sleep,
  input wire logic sample_enable,
  input wire logic neg_ref_select,
  input wire logic pos_ref_select,
  input wire logic [12:0] pin_analog_mask,
  input wire logic irq
);
  logic [31:0] wd_q;
  logic [5:0] tm_q;

  function automatic logic [12:0] exp_pins(input logic [3:0] c);
    return (c < 4'h3) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction : exp_pins

  // Last write data; a second write cannot land within two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_q <= 32'h0;
      tm_q <= 6'h0;
    end else if (psel && penable && pready && pwrite) begin
      wd_q <= pwdata;
      if (paddr == ADDR_TIMING_CONFIG) tm_q <= pwdata[5:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready held past one cycle");
  property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("pready late");
  property p_err; pslverr |-> pready && (paddr > 8'h18 || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err)
    else $error("pslverr on mapped word");
  property p_neg; s_wr(ADDR_REF_PORT_CONFIG) |-> ##2 neg_ref_select == wd_q[5]; endproperty
  a_neg: assert property (p_neg)
    else $error("negative reference wrong");
  property p_pos; s_wr(ADDR_REF_PORT_CONFIG) |-> ##2 pos_ref_select == wd_q[4]; endproperty
  a_pos: assert property (p_pos)
    else $error("positive reference wrong");
  property p_pins;
    s_wr(ADDR_REF_PORT_CONFIG) |-> ##2 pin_analog_mask == exp_pins(wd_q[3:0]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin mask wrong");
  property p_rd_zero;
    psel && penable && pready && !pwrite && paddr == ADDR_REF_PORT_CONFIG |-> prdata[31:6] == 0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("upper reference bits not zero");
  property p_irq_mask; s_wr(ADDR_IRQ_MASK) ##0 !pwdata[0] |-> ##2 !irq; endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq while masked");
  property p_start;
    s_wr(ADDR_RUN_CONTROL) ##0 (pwdata[1:0] == 2'h3 && tm_q == 6'h0 && sample_enable
      && !cpu_sleep) |-> ##[1:6] !sample_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("sampling not stopped at start");
  property p_holdoff; $rose(irq) && !sample_enable |-> !sample_enable [*4]; endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("sampling resumed too soon");
endmodule : adc_sequencing_control_props

bind adc_sequencing_control adc_sequencing_control_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .cpu_sleep(cpu_sleep),
  .sample_enable(sample_enable),
  .neg_ref_select(neg_ref_select),
  .pos_ref_select(pos_ref_select),
  .pin_analog_mask(pin_analog_mask),
  .irq(irq)
);

// File: tb/adc_sequencing_control_tb_top.sv
`timescale 1ns/1ps

module adc_sequencing_control_tb_top;
  import adc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic option, sleep, tick, comp, sample, nref, pref, irq;
  logic [3:0] chan;
  logic [11:0] dac, level, lv;
  logic [12:0] pins;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int clk_tab[6] = '{0, 4, 1, 5, 2, 6};
  int div_tab[6] = '{2, 4, 8, 16, 32, 64};

  adc_sequencing_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_port_at_reset_option(option),
    .cpu_sleep(sleep), .rc_osc_tick(tick), .comp_above(comp), .channel_sel(chan),
    .sample_enable(sample), .dac_code(dac), .neg_ref_select(nref),
    .pos_ref_select(pref), .pin_analog_mask(pins), .irq(irq));
  adc_analog_model u_front (.pclk(pclk), .sample_enable(sample), .level(level),
    .dac_code(dac), .comp_above(comp));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // RC oscillator stand-in: one tick every four clocks
  initial begin
    tick = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
    end
  end
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------
  // Tasks
  // ----------------------------------
  function automatic logic [12:0] pmask(input logic [3:0] c);
    return (c < 4'h3) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction : pmask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("wait states", 2, k);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask : rdc
  task automatic wirq;
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk("holdoff", 0, sample);
  endtask : wirq
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------
  // Tests
  // ----------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    option = 1'b1;
    sleep = 1'b0;
    level = 12'h5a3;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ref reset", ADDR_REF_PORT_CONFIG, 32'h0);
    chk("pins reset", 13'h1fff, pins);
    wr(ADDR_REF_PORT_CONFIG, 32'hff);
    rdc("ref bits", ADDR_REF_PORT_CONFIG, 32'h3f);
    chk("refs", 2'h3, {nref, pref});
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_REF_PORT_CONFIG, c);
      repeat (2) @(negedge pclk);
      chk("pins", pmask(c[3:0]), pins);
    end
    rdc("unmapped", 8'h1c, 32'h0);
    chk("slverr", 1, err);
    wr(ADDR_IRQ_MASK, 32'h1);
    // Every system-clock divider, no acquisition
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_TIMING_CONFIG, clk_tab[s]);
      wr(ADDR_RUN_CONTROL, 32'h0f);
      wirq();
      chk("divider", 1, n >= 12 * div_tab[s] && n <= 13 * div_tab[s] + 8);
      rdc("div flag", ADDR_IRQ_STATUS, 32'h1);
      // Let the holdoff finish before the divider changes under it
      repeat (2 * div_tab[s]) @(posedge pclk);
    end
    // Every acquisition code, fastest conversion clock
    for (int a = 0; a < 8; a++) begin
      wr(ADDR_TIMING_CONFIG, a << 3);
      wr(ADDR_RUN_CONTROL, 32'h0f);
      wirq();
      chk("duration", 1, n >= 2 * (acq_tab[a] + 13) - 1 && n <= 2 * (acq_tab[a] + 13) + 8);
      rdc("busy", ADDR_RUN_CONTROL, 32'h0d);
      chk("channel", 32'h3, chan);
      rdc("res hi", ADDR_RESULT_HIGH, level[11:8]);
      rdc("res lo", ADDR_RESULT_LOW, level[7:0]);
      rdc("flag", ADDR_IRQ_STATUS, 32'h1);
      rdc("flag clr", ADDR_IRQ_STATUS, 32'h0);
      chk("sampling", 1, sample);
      level <= level + 12'h111;
    end
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_TIMING_CONFIG, 32'h0);
    wr(ADDR_RUN_CONTROL, 32'h0f);
    n = 0;
    do begin
      bus(1'b0, ADDR_RUN_CONTROL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0);
    chk("masked irq", 0, irq);
    rdc("masked flag", ADDR_IRQ_STATUS, 32'h1);
    // Sleep stops the system-clock periods, not the RC ones
    wr(ADDR_IRQ_MASK, 32'h1);
    sleep <= 1'b1;
    wr(ADDR_RUN_CONTROL, 32'h0f);
    repeat (100) @(posedge pclk);
    chk("halted", 0, irq);
    sleep <= 1'b0;
    wirq();
    rdc("flag", ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_TIMING_CONFIG, 32'h3);
    sleep <= 1'b1;
    wr(ADDR_RUN_CONTROL, 32'h0f);
    wirq();
    chk("rc sleep", 1, irq === 1'b1 && n >= 48 && n <= 60);
    rdc("flag", ADDR_IRQ_STATUS, 32'h1);
    sleep <= 1'b0;
    // Reset in mid-conversion
    lv = level;
    level <= 12'h0;
    wr(ADDR_TIMING_CONFIG, 32'h30);
    wr(ADDR_RUN_CONTROL, 32'h0f);
    // Past the acquisition, well inside the conversion
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    option <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("run reset", ADDR_RUN_CONTROL, 32'h0);
    rdc("kept hi", ADDR_RESULT_HIGH, lv[11:8]);
    rdc("kept lo", ADDR_RESULT_LOW, lv[7:0]);
    rdc("ref option", ADDR_REF_PORT_CONFIG, 32'h7);
    chk("pins option", 13'h00ff, pins);
    chk("irq reset", 0, irq);
    wrap_up();
  end
endmodule : adc_sequencing_control_tb_top
